/* core/cisr_pkg.sv */
// cisr_pkg: constants, register map and carrier types for the card interrupt steering block
// assumes a single 25 MHz clock domain and a classic wishbone slave with 32-bit data
package cisr_pkg;

    // --------------------
    // sizes
    // --------------------
    localparam int NUM_SOCK = 2;
    localparam int NUM_IRQ = 10;
    localparam int NUM_STB = 2;

    // --------------------
    // register byte offsets (index times four)
    // --------------------
    localparam logic [7:0] IDX_INT_GEN = 8'h03;
    localparam logic [7:0] IDX_MISC2 = 8'h1e;
    localparam logic [9:0] OFF_INT_GEN0 = 10'h00c;
    localparam logic [9:0] OFF_EXT_CTL0 = 10'h10c;
    localparam logic [9:0] OFF_INT_GEN1 = 10'h20c;
    localparam logic [9:0] OFF_EXT_CTL1 = 10'h30c;
    localparam logic [9:0] OFF_MISC2 = 10'h078;
    localparam logic [9:0] OFF_STEER0 = 10'h040;
    localparam logic [9:0] OFF_STEER1 = 10'h044;
    localparam logic [9:0] OFF_MGMT_EN0 = 10'h048;
    localparam logic [9:0] OFF_MGMT_EN1 = 10'h04c;
    localparam logic [9:0] OFF_MGMT_STAT0 = 10'h050;
    localparam logic [9:0] OFF_MGMT_STAT1 = 10'h054;
    localparam logic [9:0] OFF_STB_CFG = 10'h058;
    localparam logic [9:0] OFF_STB_PORT0 = 10'h05c;
    localparam logic [9:0] OFF_STB_PORT1 = 10'h060;
    localparam logic [9:0] OFF_PIN_STAT = 10'h064;

    // --------------------
    // field positions
    // --------------------
    localparam int BIT_RING_EN = 7;   // interrupt_general_control
    localparam int BIT_IO_CARD = 5;
    localparam int BIT_ACT_LAMP = 2;  // extension_control_one
    localparam int BIT_RING_SEL = 7;  // miscellaneous_control_two
    localparam int BIT_DMA_SEL = 6;
    localparam int BIT_DRIVE_LAMP = 4;
    localparam int BIT_SUSPEND = 2;
    localparam int BIT_SHARE = 4;     // unused; the steering register share bit is bit 8
    localparam int BIT_ACTIVE = 5;    // interrupt_general_control, card activated

    // --------------------
    // reset values and timing
    // --------------------
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_MISC2 = 8'h02;
    localparam logic [3:0] IRQ_NONE = 4'h0;
    localparam int PULSE_NS = 200;
    localparam int CLK_NS = 40;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;

    // --------------------
    // carrier types
    // --------------------
    typedef struct packed {
        logic card_present;
        logic ready_ireq;
        logic bvd1_stschg;
        logic bvd2_spkr;
        logic cycle_active;
    } cisr_sock_t;

    typedef struct packed {
        logic [NUM_IRQ-1:0] out;
        logic [NUM_IRQ-1:0] oe;
    } cisr_irq_t;

    // steering code 1..10 selects pin code-1, 0 selects none
    typedef struct packed {
        logic share;
        logic [3:0] mgmt_sel;
        logic [3:0] card_sel;
    } cisr_steer_t;

endpackage : cisr_pkg

/* core/cisr_top.sv */
// cisr_top: interrupt steering, lamp, ring wake, dma pin redefinition and general strobes
// assumes socket inputs and isa pins are asynchronous and pass two flops before use
`timescale 1ns/100ps
module cisr_top #(
    parameter int PULSE_CYC = cisr_pkg::PULSE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire cisr_pkg::cisr_sock_t [cisr_pkg::NUM_SOCK-1:0] sock_i,
    input wire logic isa_access_i,
    input wire logic dack_n_i,
    input wire logic dma_req_i,
    input wire logic volt_sense_i,
    input wire logic [7:0] ext_port_i,
    output cisr_pkg::cisr_irq_t irq_o,
    output logic [cisr_pkg::NUM_STB-1:0] general_strobe_o,
    output logic [7:0] ext_port_o
);

    localparam int NS = cisr_pkg::NUM_SOCK;
    localparam int NI = cisr_pkg::NUM_IRQ;

    // --------------------
    // decode helpers
    // --------------------
    function automatic logic [NI-1:0] cisr_pin_dec(input logic [3:0] code);
        logic [NI-1:0] v;
        v = '0;
        if (code != cisr_pkg::IRQ_NONE && code <= 4'(NI))
        begin
            v[code - 4'h1] = 1'b1;
        end
        return v;
    endfunction : cisr_pin_dec

    // --------------------
    // input synchronisers
    // --------------------
    cisr_pkg::cisr_sock_t [NS-1:0] sock_m_ff, sock_s_ff, sock_d_ff;
    logic [3:0] misc_m_ff, misc_s_ff;
    logic [7:0] port_m_ff, port_s_ff;

    // two-flop capture, first stage read only by second
    always_ff @(posedge clk_i)
    begin
        sock_m_ff <= sock_i;
        sock_s_ff <= sock_m_ff;
        sock_d_ff <= sock_s_ff;
        misc_m_ff <= {isa_access_i, dack_n_i, dma_req_i, volt_sense_i};
        misc_s_ff <= misc_m_ff;
        port_m_ff <= ext_port_i;
        port_s_ff <= port_m_ff;
    end

    // --------------------
    // registers
    // --------------------
    logic [7:0] int_gen_ff [NS];
    logic [7:0] ext_ctl_ff [NS];
    logic [7:0] misc2_ff;
    cisr_pkg::cisr_steer_t steer_ff [NS];
    logic [3:0] mgmt_en_ff [NS];
    logic [3:0] mgmt_stat_ff [NS];
    logic [1:0] stb_cfg_ff;
    logic [7:0] ext_port_ff;
    logic ack_ff;
    logic [31:0] dat_ff;

    wire req = cyc_i && stb_i && !ack_ff;
    wire wr = req && we_i && sel_i[0];
    wire [7:0] wd = dat_i[7:0];

    // single registered ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= req;
    end

    // miscellaneous_control_two and strobe configuration writes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            misc2_ff <= cisr_pkg::RST_MISC2;
            stb_cfg_ff <= '0;
            ext_port_ff <= cisr_pkg::RST_REG;
        end
        else if (wr)
        begin
            if (adr_i == cisr_pkg::OFF_MISC2)
                misc2_ff <= wd;
            if (adr_i == cisr_pkg::OFF_STB_CFG)
                stb_cfg_ff <= wd[1:0];
            if (adr_i == cisr_pkg::OFF_STB_PORT0 || adr_i == cisr_pkg::OFF_STB_PORT1)
                ext_port_ff <= wd;
        end
    end

    // --------------------
    // per-socket logic
    // --------------------
    logic [NS-1:0] card_irq, lamp_req, ring_req;
    logic [NI-1:0] card_pins [NS];
    logic [NI-1:0] mgmt_pins [NS];
    logic [NS-1:0] share_s;

    genvar s;
    generate
        for (s = 0; s < NS; s++)
        begin : g_sock
            localparam logic [9:0] OIG = s ? cisr_pkg::OFF_INT_GEN1 : cisr_pkg::OFF_INT_GEN0;
            localparam logic [9:0] OEC = s ? cisr_pkg::OFF_EXT_CTL1 : cisr_pkg::OFF_EXT_CTL0;
            localparam logic [9:0] OST = s ? cisr_pkg::OFF_STEER1 : cisr_pkg::OFF_STEER0;
            localparam logic [9:0] OME = s ? cisr_pkg::OFF_MGMT_EN1 : cisr_pkg::OFF_MGMT_EN0;
            localparam logic [9:0] OMS = s ? cisr_pkg::OFF_MGMT_STAT1 : cisr_pkg::OFF_MGMT_STAT0;
            wire io_card = int_gen_ff[s][cisr_pkg::BIT_IO_CARD];
            wire present = sock_s_ff[s].card_present;
            wire active = present && int_gen_ff[s][cisr_pkg::BIT_ACTIVE];
            logic [3:0] evt;

            // socket control registers
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    int_gen_ff[s] <= cisr_pkg::RST_REG;
                    ext_ctl_ff[s] <= cisr_pkg::RST_REG;
                    steer_ff[s] <= '0;
                    mgmt_en_ff[s] <= '0;
                end
                else if (wr)
                begin
                    if (adr_i == OIG)
                        int_gen_ff[s] <= wd;
                    if (adr_i == OEC)
                        ext_ctl_ff[s] <= wd;
                    if (adr_i == OST)
                        steer_ff[s] <= cisr_pkg::cisr_steer_t'(dat_i[8:0]);
                    if (adr_i == OME)
                        mgmt_en_ff[s] <= wd[3:0];
                end
            end

            // status edges: detect, bvd2 (mem), bvd1/stschg, ready (mem)
            always_comb
            begin
                evt[0] = sock_s_ff[s].card_present ^ sock_d_ff[s].card_present;
                evt[1] = !io_card && (sock_s_ff[s].bvd2_spkr ^ sock_d_ff[s].bvd2_spkr);
                evt[2] = sock_s_ff[s].bvd1_stschg ^ sock_d_ff[s].bvd1_stschg;
                evt[3] = !io_card && (sock_s_ff[s].ready_ireq ^ sock_d_ff[s].ready_ireq);
            end

            // latched flags, write one to clear, set wins
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    mgmt_stat_ff[s] <= '0;
                else
                    mgmt_stat_ff[s] <= (mgmt_stat_ff[s] & ~((wr && adr_i == OMS) ? wd[3:0] : 4'h0))
                        | evt;
            end

            // socket-class source, active low ireq on io card
            assign card_irq[s] = present && io_card && !sock_s_ff[s].ready_ireq;
            assign card_pins[s] = cisr_pin_dec(steer_ff[s].card_sel);
            assign mgmt_pins[s] = cisr_pin_dec(steer_ff[s].mgmt_sel);
            assign share_s[s] = steer_ff[s].share;

            // lamp sources, masked when card absent or inactive
            assign lamp_req[s] = active && (
                (ext_ctl_ff[s][cisr_pkg::BIT_ACT_LAMP] && sock_s_ff[s].cycle_active)
                || (misc2_ff[cisr_pkg::BIT_DRIVE_LAMP] && io_card
                    && !sock_s_ff[s].bvd2_spkr));

            // ring qualified by enable and io card
            assign ring_req[s] = present && io_card && int_gen_ff[s][cisr_pkg::BIT_RING_EN]
                && !sock_s_ff[s].bvd1_stschg;
        end
    endgenerate

    // --------------------
    // steering merge
    // --------------------
    logic [NI-1:0] lvl, assigned, share_pins;
    always_comb
    begin
        lvl = '0;
        assigned = '0;
        share_pins = '0;
        for (int i = 0; i < NS; i++)
        begin
            if (card_irq[i])
                lvl = lvl | card_pins[i];
            if (|(mgmt_stat_ff[i] & mgmt_en_ff[i]))
                lvl = lvl | mgmt_pins[i];
            assigned = assigned | card_pins[i] | mgmt_pins[i];
            if (share_s[i])
                share_pins = share_pins | card_pins[i] | mgmt_pins[i];
        end
    end

    // --------------------
    // shared-mode pulse per pin
    // --------------------
    logic [NI-1:0] lvl_d_ff, pulse_on;
    logic [7:0] pcnt_ff [NI];
    genvar p;
    generate
        for (p = 0; p < NI; p++)
        begin : g_pulse
            // rising source starts a fixed pulse, then pin releases
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    pcnt_ff[p] <= '0;
                    lvl_d_ff[p] <= 1'b0;
                end
                else
                begin
                    lvl_d_ff[p] <= lvl[p];
                    if (lvl[p] && !lvl_d_ff[p])
                        pcnt_ff[p] <= 8'(PULSE_CYC);
                    else if (pcnt_ff[p] != 8'h00)
                        pcnt_ff[p] <= pcnt_ff[p] - 8'h01;
                end
            end
            assign pulse_on[p] = pcnt_ff[p] != 8'h00;
        end
    endgenerate

    // --------------------
    // ring wake latch
    // --------------------
    logic ring_wake_ff;
    wire ring_sel = misc2_ff[cisr_pkg::BIT_RING_SEL];
    // held low until isa bus activity, passes in suspend too
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ring_wake_ff <= 1'b0;
        else if (ring_sel && |ring_req)
            ring_wake_ff <= 1'b1;
        else if (misc_s_ff[3] || !ring_sel)
            ring_wake_ff <= 1'b0;
    end

    // --------------------
    // pin drive
    // --------------------
    logic [NI-1:0] nxt_out, nxt_oe;
    wire dma_sel = misc2_ff[cisr_pkg::BIT_DMA_SEL];
    wire lamp_mode = |{ext_ctl_ff[0][cisr_pkg::BIT_ACT_LAMP], ext_ctl_ff[1][cisr_pkg::BIT_ACT_LAMP],
        misc2_ff[cisr_pkg::BIT_DRIVE_LAMP]};

    // steered drive, shared pulses, alternate pin functions
    always_comb
    begin
        for (int i = 0; i < NI; i++)
        begin
            if (share_pins[i])
            begin
                nxt_out[i] = 1'b1;
                nxt_oe[i] = pulse_on[i];
            end
            else
            begin
                nxt_out[i] = lvl[i];
                nxt_oe[i] = assigned[i];
            end
        end
        // pin 3 is irq9, pin 4 irq10, pin 5 irq12, pin 8 irq15
        if (lamp_mode)
        begin
            nxt_out[5] = 1'b0;
            nxt_oe[5] = |lamp_req;
        end
        if (ring_sel)
        begin
            nxt_out[8] = !ring_wake_ff;
            nxt_oe[8] = 1'b1;
        end
        if (dma_sel)
        begin
            nxt_out[3] = 1'b0;
            nxt_oe[3] = 1'b0;
            nxt_out[4] = misc_s_ff[1];
            nxt_oe[4] = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= '0;
        else
            irq_o <= '{out: nxt_out, oe: nxt_oe};
    end

    // --------------------
    // general strobes on virtual registers
    // --------------------
    logic [cisr_pkg::NUM_STB-1:0] nxt_stb;
    always_comb
    begin
        // cfg bit set selects read direction, clear selects write
        nxt_stb[0] = cyc_i && stb_i && adr_i == cisr_pkg::OFF_STB_PORT0
            && (we_i != stb_cfg_ff[0]);
        nxt_stb[1] = cyc_i && stb_i && adr_i == cisr_pkg::OFF_STB_PORT1
            && (we_i != stb_cfg_ff[1]);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            general_strobe_o <= '0;
            ext_port_o <= '0;
        end
        else
        begin
            general_strobe_o <= nxt_stb & {NS{!ack_ff}};
            ext_port_o <= ext_port_ff;
        end
    end

    // --------------------
    // read mux
    // --------------------
    logic [31:0] nxt_dat;
    always_comb
    begin
        nxt_dat = 32'h0000_0000;
        unique case (adr_i)
            cisr_pkg::OFF_INT_GEN0: nxt_dat[7:0] = int_gen_ff[0];
            cisr_pkg::OFF_INT_GEN1: nxt_dat[7:0] = int_gen_ff[1];
            cisr_pkg::OFF_EXT_CTL0: nxt_dat[7:0] = ext_ctl_ff[0];
            cisr_pkg::OFF_EXT_CTL1: nxt_dat[7:0] = ext_ctl_ff[1];
            cisr_pkg::OFF_MISC2: nxt_dat[7:0] = misc2_ff;
            cisr_pkg::OFF_STEER0: nxt_dat[8:0] = steer_ff[0];
            cisr_pkg::OFF_STEER1: nxt_dat[8:0] = steer_ff[1];
            cisr_pkg::OFF_MGMT_EN0: nxt_dat[3:0] = mgmt_en_ff[0];
            cisr_pkg::OFF_MGMT_EN1: nxt_dat[3:0] = mgmt_en_ff[1];
            cisr_pkg::OFF_MGMT_STAT0: nxt_dat[3:0] = mgmt_stat_ff[0];
            cisr_pkg::OFF_MGMT_STAT1: nxt_dat[3:0] = mgmt_stat_ff[1];
            cisr_pkg::OFF_STB_CFG: nxt_dat[1:0] = stb_cfg_ff;
            cisr_pkg::OFF_STB_PORT0, cisr_pkg::OFF_STB_PORT1: nxt_dat[7:0] = port_s_ff;
            cisr_pkg::OFF_PIN_STAT: nxt_dat[3:0] = {ring_wake_ff, |lamp_req,
                misc_s_ff[2], misc_s_ff[0]};
            default: nxt_dat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_ff <= '0;
        else if (req && !we_i)
            dat_ff <= nxt_dat;
    end

    assign ack_o = ack_ff;
    assign dat_o = dat_ff;

endmodule : cisr_top

/* test/cisr_isa_host.sv */
// cisr_isa_host: isa side model, pulled-up irq lines, bus activity, dma acknowledge
// assumes every irq line has a board pull-up; lag sets how slowly bus activity resumes
`timescale 1ns/100ps
module cisr_isa_host (
    input wire logic clk_i,
    input wire cisr_pkg::cisr_irq_t irq_i,
    input wire logic resume_i,
    input wire logic [3:0] lag_i,
    output logic [9:0] pin_o,
    output logic isa_access_o,
    output logic dack_n_o
);
    logic [3:0] wait_ff;

    // released line reads the pull-up level
    assign pin_o = (irq_i.out & irq_i.oe) | ~irq_i.oe;

    // acknowledge on the channel of the request pin
    assign dack_n_o = !(irq_i.oe[4] === 1'b1 && irq_i.out[4] === 1'b1);

    // two cycles of bus reads after the lag
    assign isa_access_o = resume_i && wait_ff >= lag_i && wait_ff <= lag_i + 4'h1;

    // lag counter while resume is asked for
    always_ff @(posedge clk_i)
    begin
        wait_ff <= !resume_i ? 4'h0 : wait_ff + {3'h0, wait_ff != 4'hf};
    end
endmodule : cisr_isa_host

/* test/cisr_top_asserts.sv */
// cisr_top_asserts: port-level checks for the card interrupt steering block
// assumes a bind onto cisr_top, one clock domain, synchronous active-high reset
`timescale 1ns/100ps
module cisr_top_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic isa_access_i,
    input wire cisr_pkg::cisr_sock_t [cisr_pkg::NUM_SOCK-1:0] sock_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire cisr_pkg::cisr_irq_t irq_o,
    input wire logic [cisr_pkg::NUM_STB-1:0] general_strobe_o
);
    // --------------------
    // helper ages and sequences
    // --------------------
    logic [3:0] quiet_ff, ring_ff, lamp_ff;

    // any low ring input, any present socket asking for the lamp
    wire ring_src = !sock_i[0].bvd1_stschg || !sock_i[1].bvd1_stschg;
    wire lamp_src = (sock_i[0].card_present && (sock_i[0].cycle_active || !sock_i[0].bvd2_spkr))
        || (sock_i[1].card_present && (sock_i[1].cycle_active || !sock_i[1].bvd2_spkr));

    // saturating cycle ages since last bus activity, ring and lamp cause
    always_ff @(posedge clk_i)
    begin
        quiet_ff <= (isa_access_i || cyc_i || rst_i) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hf};
        ring_ff <= ring_src ? 4'h0 : (rst_i ? 4'hf : ring_ff + {3'h0, ring_ff != 4'hf});
        lamp_ff <= lamp_src ? 4'h0 : (rst_i ? 4'hf : lamp_ff + {3'h0, lamp_ff != 4'hf});
    end

    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_wake;
        irq_o.oe[8] && !irq_o.out[8];
    endsequence

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // --------------------
    // assertions
    // --------------------
    AST_ACK_NEXT: assert property (s_req |=> ack_o)
        else $error("ack missing after request");
    AST_ACK_ONE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_STB_IN_BUS: assert property (|general_strobe_o |-> cyc_i && stb_i)
        else $error("strobe outside a bus access");
    AST_STB_ACK: assert property ($rose(|general_strobe_o) |-> ack_o)
        else $error("strobe rose without ack");
    AST_STB_DROP: assert property (ack_o |=> general_strobe_o == '0)
        else $error("strobe held past ack");
    AST_DAT_HOLD: assert property ($changed(dat_o) |-> ack_o && !we_i)
        else $error("read data moved outside a read");
    AST_RST_QUIET: assert property ($fell(rst_i) |-> irq_o.oe == '0)
        else $error("irq pin driven out of reset");
    AST_WAKE_CAUSE: assert property ($rose(irq_o.oe[8] && !irq_o.out[8]) |-> ring_ff < 4'h8)
        else $error("wake without ring");
    AST_WAKE_HOLD: assert property (quiet_ff > 4'h8 ##0 s_wake |=> s_wake)
        else $error("wake released without bus activity");
    AST_LAMP_CAUSE: assert property ($rose(irq_o.oe[5] && !irq_o.out[5]) |-> lamp_ff < 4'h8)
        else $error("lamp lit without a present source");
endmodule : cisr_top_asserts

bind cisr_top cisr_top_asserts u_cisr_top_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .isa_access_i(isa_access_i), .sock_i(sock_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o), .general_strobe_o(general_strobe_o)
);

/* test/test_cisr_top.sv */
// test_cisr_top: self-checking bench for the card interrupt steering block
// assumes the isa host model on the pins and the bound port checker
`timescale 1ns/100ps
module test_cisr_top;
    // --------------------
    // signals and instances
    // --------------------
    localparam int PCYC = 3;
    localparam logic [9:0] RA [6] = '{10'h00c, 10'h10c, 10'h078, 10'h040, 10'h050, 10'h3fc};
    localparam logic [7:0] RV [6] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic dma_req_i = 1'b0, volt_sense_i = 1'b0, resume = 1'b0, ack_o, isa_access_i, dack_n_i;
    logic [9:0] adr_i = 10'h000, pin;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
    logic [7:0] ext_port_i = 8'h00, ext_port_o;
    logic [3:0] lag = 4'h0;
    logic [1:0] general_strobe_o, last_stb;
    cisr_pkg::cisr_sock_t [1:0] sock_i = 10'h3de;
    cisr_pkg::cisr_irq_t irq_o;
    int err_count = 0, tests_run = 0, cyc_count = 0;

    cisr_top #(.PULSE_CYC(PCYC)) u_cisr_top (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sock_i(sock_i), .isa_access_i(isa_access_i), .dack_n_i(dack_n_i),
        .dma_req_i(dma_req_i), .volt_sense_i(volt_sense_i), .ext_port_i(ext_port_i),
        .irq_o(irq_o), .general_strobe_o(general_strobe_o), .ext_port_o(ext_port_o)
    );
    cisr_isa_host u_cisr_isa_host (
        .clk_i(clk_i), .irq_i(irq_o), .resume_i(resume), .lag_i(lag), .pin_o(pin),
        .isa_access_o(isa_access_i), .dack_n_o(dack_n_i)
    );

    // --------------------
    // clock, timeout, tasks
    // --------------------
    // 25 MHz clock
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    // hang guard
    always @(posedge clk_i)
    begin
        cyc_count++;
        if (cyc_count == 20000)
        begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // classic single cycle, held until ack
    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1);
        rd = dat_o;
        last_stb = general_strobe_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb

    function automatic logic [31:0] stb_exp(input logic [1:0] cfg, input int n, input logic r);
        return (cfg[n] == r) ? 32'(1 << n) : 32'h0000_0000;
    endfunction : stb_exp

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    // --------------------
    // main sequence
    // --------------------
    initial
    begin
        int i, n, code;
        logic [31:0] d;
        logic [1:0] cfg;
        void'($urandom(22));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("pins released", 32'(irq_o.oe), 32'h0);
        foreach (RA[k])
        begin
            wb(1'b0, RA[k], 32'h0);
            chk("reset value", rd, {24'h0, RV[k]});
        end
        $display("test reset done");
        for (i = 0; i < 6; i++)
        begin
            code = 1 + int'($urandom % 10);
            code = (code == 6 || code == 9) ? 3 : code;
            wb(1'b1, cisr_pkg::OFF_MISC2, 32'h02);
            wb(1'b1, cisr_pkg::OFF_INT_GEN0, 32'h20);
            wb(1'b1, cisr_pkg::OFF_STEER0, 32'(code));
            wb(1'b1, cisr_pkg::OFF_MISC2, i[0] ? 32'h06 : 32'h02);
            sock_i[0].ready_ireq <= 1'b0;
            repeat (8) @(posedge clk_i);
            chk("card irq", 32'(irq_o.oe[code-1] & irq_o.out[code-1]), 32'h1);
            chk("other pins", 32'(irq_o.oe & ~(10'h1 << (code - 1))), 32'h0);
            sock_i[0].ready_ireq <= 1'b1;
            repeat (8) @(posedge clk_i);
        end
        wb(1'b1, cisr_pkg::OFF_MISC2, 32'h02);
        $display("test steering done");
        wb(1'b1, cisr_pkg::OFF_STEER0, 32'h25);
        wb(1'b1, cisr_pkg::OFF_MGMT_EN0, 32'h01);
        wb(1'b1, cisr_pkg::OFF_MGMT_STAT0, 32'h0f);
        sock_i[0].card_present <= 1'b0;
        repeat (8) @(posedge clk_i);
        wb(1'b0, cisr_pkg::OFF_MGMT_STAT0, 32'h0);
        chk("detect flag", rd & 32'h1, 32'h1);
        chk("mgmt pin", {31'h0, irq_o.oe[1] & irq_o.out[1]}, 32'h1);
        chk("card pin idle", {31'h0, irq_o.out[4]}, 32'h0);
        sock_i[0].card_present <= 1'b1;
        repeat (8) @(posedge clk_i);
        wb(1'b1, cisr_pkg::OFF_MGMT_STAT0, 32'h0f);
        repeat (3) @(posedge clk_i);
        chk("mgmt cleared", {31'h0, irq_o.out[1]}, 32'h0);
        $display("test management done");
        wb(1'b1, cisr_pkg::OFF_STEER0, 32'h103);
        sock_i[0].ready_ireq <= 1'b0;
        repeat (2) @(posedge clk_i);
        sock_i[0].ready_ireq <= 1'b1;
        n = 0;
        repeat (30)
        begin
            @(posedge clk_i);
            n += int'(irq_o.oe[2] & irq_o.out[2]);
        end
        chk("pulse length", 32'(n), 32'(PCYC));
        chk("pulse released", {31'h0, irq_o.oe[2]}, 32'h0);
        wb(1'b1, cisr_pkg::OFF_STEER0, 32'h0);
        $display("test shared done");
        wb(1'b1, cisr_pkg::OFF_EXT_CTL0, 32'h04);
        sock_i[0].cycle_active <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("activity lamp", {31'h0, pin[5]}, 32'h0);
        sock_i[0].cycle_active <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("lamp off", {31'h0, pin[5]}, 32'h1);
        wb(1'b1, cisr_pkg::OFF_INT_GEN1, 32'h20);
        wb(1'b1, cisr_pkg::OFF_MISC2, 32'h12);
        sock_i[1].bvd2_spkr <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("drive lamp", 32'(pin[5]), 32'h0);
        sock_i[1].card_present <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("absent masked", {31'h0, pin[5]}, 32'h1);
        sock_i[1] <= 5'h1e;
        wb(1'b1, cisr_pkg::OFF_EXT_CTL0, 32'h0);
        $display("test lamp done");
        for (i = 0; i < 2; i++)
        begin
            wb(1'b1, cisr_pkg::OFF_MISC2, 32'h82);
            wb(1'b1, cisr_pkg::OFF_INT_GEN0, i[0] ? 32'ha0 : 32'h20);
            sock_i[0].bvd1_stschg <= 1'b0;
            repeat (6) @(posedge clk_i);
            sock_i[0].bvd1_stschg <= 1'b1;
            repeat (12) @(posedge clk_i);
            chk("ring wake", {31'h0, pin[8]}, {31'h0, !i[0]});
            lag <= 4'($urandom % 8);
            resume <= 1'b1;
            repeat (16) @(posedge clk_i);
            resume <= 1'b0;
            chk("wake cleared", {31'h0, pin[8]}, 32'h1);
        end
        $display("test ring done");
        wb(1'b1, cisr_pkg::OFF_MISC2, 32'h42);
        for (i = 0; i < 4; i++)
        begin
            dma_req_i <= 1'($urandom);
            repeat (4) @(posedge clk_i);
            chk("drq pin", {30'h0, irq_o.oe[4], irq_o.out[4]}, {30'h1, dma_req_i});
            chk("dack pin input", {31'h0, irq_o.oe[3]}, 32'h0);
        end
        $display("test dma done");
        for (i = 0; i < 2; i++)
        begin
            cfg = i[0] ? 2'b01 : 2'b10;
            wb(1'b1, cisr_pkg::OFF_STB_CFG, 32'(cfg));
            for (n = 0; n < 2; n++)
            begin
                d = $urandom;
                ext_port_i <= d[15:8];
                wb(1'b1, n ? cisr_pkg::OFF_STB_PORT1 : cisr_pkg::OFF_STB_PORT0, {24'h0, d[7:0]});
                chk("write strobe", 32'(last_stb), stb_exp(cfg, n, 1'b0));
                wb(1'b0, n ? cisr_pkg::OFF_STB_PORT1 : cisr_pkg::OFF_STB_PORT0, 32'h0);
                chk("port out", 32'(ext_port_o), {24'h0, d[7:0]});
                chk("read strobe", 32'(last_stb), stb_exp(cfg, n, 1'b1));
                if (cfg[n])
                    chk("port in", rd, {24'h0, d[15:8]});
            end
            volt_sense_i <= i[0];
            repeat (4) @(posedge clk_i);
            wb(1'b0, cisr_pkg::OFF_PIN_STAT, 32'h0);
            chk("volt sense", rd & 32'h1, 32'(i));
        end
        $display("test strobe done");
        summarize();
    end
endmodule : test_cisr_top
